// File: core/tcrp_core.sv
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// RULE1 - Math digit result is stored first, then linearization and final stage run.
// RULE2 - Math digit zero leaves the result register untouched, no computation.
// RULE3 - pH function uses channel 1 as buffer temperature, channel 2 as pH.
// RULE4 - Math digit 2 loads channel 1 to result, channel 2 to setpoint 2.
// RULE5 - Math digit 3 loads channel 1 plus channel 2.
// RULE6 - Digit 4 loads channel 1 minus channel 2; digit 7 loads channel 1.
// RULE7 - Ratio: channel 1 times 20 000 divided by channel 2.
// RULE8 - Product: channel 1 times channel 2 divided by 10 000.
// RULE9 - First digit: 0 direct, 1 square root, 2 reciprocal.
// RULE10 - Second digit: none, one table, cascaded 125 points, or rear-selected table; the cascade here spans the 32 stored breakpoints.
// RULE11 - Tables unusable if channels 2-4 analog; channel 1 must be voltage/current.
// RULE12 - Small memory refuses linearization codes 2 through 6.
// RULE13 - Four tables only with large memory, otherwise one shared table.
// RULE14 - Large memory: channels 1,2 any table, channel 3 table 3, channel 4 table 4.
// RULE15 - Unavailable configuration writes are rejected, previous setting kept.
module tcrp_core (
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Channel inputs and status
  input  wire logic [31:0] ch1_value,
  input  wire logic [31:0] ch2_value,
  input  wire logic        sample_strobe,
  input  wire logic        mem_large,
  input  wire logic        ch1_volt_curr,
  input  wire logic [2:0]  ch_analog,
  input  wire logic [1:0]  rear_table_sel,
  input  wire logic [1:0]  ch1_table_sel,
  input  wire logic [1:0]  ch2_table_sel,
  // Results
  output logic [31:0]      result_value,
  output logic [31:0]      final_value,
  output logic [31:0]      setpoint2_value,
  output logic             result_valid,
  output logic [1:0]       ch1_table,
  output logic [1:0]       ch2_table,
  output logic [1:0]       ch3_table,
  output logic [1:0]       ch4_table
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0]           d1;
    logic [3:0]           d2;
    logic [3:0]           d3;
    logic                 rejected;
    logic                 ph_bypass;
    tcrp_pkg::tcrp_state_e st;
    logic [31:0]          result;
    logic [31:0]          work;
    logic [31:0]          final_v;
    logic [31:0]          sp2;
    logic                 valid;
    logic                 dph_act;
    logic                 dph_wr;
    logic [7:0]           dph_addr;
    logic [31:0]          rdata;
    logic [4:0]           cnt;
    logic [31:0]          sq_rem;
    logic [15:0]          sq_root;
    logic [0:31][31:0]    tab;
  } tcrp_core_s;

  tcrp_core_s s_r;
  tcrp_core_s s_nxt;

  logic        div_start;
  logic [63:0] div_dividend;
  logic [31:0] div_divisor;
  logic        div_busy;
  logic [31:0] div_quot;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Checks a proposed configuration against memory and channel modes
  function automatic logic cfg_ok(input logic [3:0] d1, input logic [3:0] d2, input logic [3:0] d3,
                                  input logic big, input logic v_i, input logic [2:0] ana);
    logic ok;
    ok = (d1 <= tcrp_pkg::FIN_INV) && (d2 <= tcrp_pkg::LIN_REAR) && (d3 <= tcrp_pkg::MATH_CH1);
    if (!big && d2 >= 4'h2) begin
      ok = 1'b0;                                               // [RULE12]
    end
    if (d2 != tcrp_pkg::LIN_NONE && ((ana != 3'h0) || !v_i)) begin
      ok = 1'b0;                                               // [RULE11]
    end
    return ok;
  endfunction : cfg_ok

  // Piecewise-linear lookup over a segment of breakpoints (value in low 16, output in high 16)
  function automatic logic [31:0] lin_seg(input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] dx;
    logic [31:0] span;
    logic [47:0] prod;
    dx   = x - {16'h0, lo[15:0]};
    span = {16'h0, hi[15:0]} - {16'h0, lo[15:0]};
    prod = 48'(dx[15:0] * (hi[31:16] - lo[31:16]));
    return (span == 32'h0) ? {16'h0, lo[31:16]} : {16'h0, lo[31:16]} + 32'(prod[47:0] / 48'(span));
  endfunction : lin_seg

  // ------------------------------------------------------------
  // Table selection per channel
  // ------------------------------------------------------------
  assign ch1_table = mem_large ? ch1_table_sel : 2'h0;        // [RULE13] [RULE14]
  assign ch2_table = mem_large ? ch2_table_sel : 2'h0;        // [RULE14]
  assign ch3_table = mem_large ? 2'h2 : 2'h0;                  // [RULE14]
  assign ch4_table = mem_large ? 2'h3 : 2'h0;                  // [RULE14]

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  tcrp_divider u_div (
    .clock    (clock),
    .rst      (rst),
    .start    (div_start),
    .dividend (div_dividend),
    .divisor  (div_divisor),
    .busy     (div_busy),
    .quotient (div_quot)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Bus, configuration and sequencer all in one pass; divider shared by pH, ratio, product and inverse
  always_comb begin
    logic [3:0]  n1;
    logic [3:0]  n2;
    logic [3:0]  n3;
    logic [1:0]  tsel;
    logic [4:0]  idx;
    logic [31:0] trial;
    n1 = '0; n2 = '0; n3 = '0; tsel = '0; idx = '0; trial = '0;
    s_nxt        = s_r;
    div_start    = 1'b0;
    div_dividend = '0;
    div_divisor  = 32'h1;

    // Data phase of the previous address phase
    if (s_r.dph_act) begin
      s_nxt.dph_act = 1'b0;
      if (s_r.dph_wr) begin
        if (s_r.dph_addr == tcrp_pkg::OFS_CFG) begin
          n1 = hwdata[tcrp_pkg::CFG_D1_LSB +: 4];
          n2 = hwdata[tcrp_pkg::CFG_D2_LSB +: 4];
          n3 = hwdata[tcrp_pkg::CFG_D3_LSB +: 4];
          if (cfg_ok(n1, n2, n3, mem_large, ch1_volt_curr, ch_analog)) begin
            s_nxt.d1 = n1;
            s_nxt.d2 = n2;
            s_nxt.d3 = n3;
            s_nxt.rejected = 1'b0;
          end else begin
            s_nxt.rejected = 1'b1;                             // [RULE15]
          end
        end else if (s_r.dph_addr == tcrp_pkg::OFS_CTRL) begin
          s_nxt.ph_bypass = hwdata[0];
        end else if (s_r.dph_addr >= tcrp_pkg::OFS_TAB_BASE) begin
          s_nxt.tab[s_r.dph_addr[6:2]] = hwdata;
        end
      end
    end

    // Address phase capture
    if (hsel && hready && htrans[1]) begin
      s_nxt.dph_act  = 1'b1;
      s_nxt.dph_wr   = hwrite;
      s_nxt.dph_addr = {haddr[7:2], 2'b00};
      case ({haddr[7:2], 2'b00})
        tcrp_pkg::OFS_CFG:    s_nxt.rdata = {20'h0, s_r.d1, s_r.d2, s_r.d3};
        tcrp_pkg::OFS_STATUS: s_nxt.rdata = {27'h0, mem_large, s_r.rejected, s_r.valid, s_r.st != tcrp_pkg::ST_IDLE, 1'b0};
        tcrp_pkg::OFS_CH1:    s_nxt.rdata = ch1_value;
        tcrp_pkg::OFS_CH2:    s_nxt.rdata = ch2_value;
        tcrp_pkg::OFS_RESULT: s_nxt.rdata = s_r.result;
        tcrp_pkg::OFS_OUT:    s_nxt.rdata = s_r.final_v;
        tcrp_pkg::OFS_SP2:    s_nxt.rdata = s_r.sp2;
        tcrp_pkg::OFS_CTRL:   s_nxt.rdata = {31'h0, s_r.ph_bypass};
        default: begin
          s_nxt.rdata = haddr[7] ? s_r.tab[haddr[6:2]] : 32'h0;
        end
      endcase
    end

    // Processing sequencer
    case (s_r.st)
      tcrp_pkg::ST_IDLE: begin
        if (sample_strobe) begin
          s_nxt.valid = 1'b0;
          case (s_r.d3)
            tcrp_pkg::MATH_NONE: s_nxt.st = tcrp_pkg::ST_LIN;  // [RULE2]
            tcrp_pkg::MATH_PH: begin
              // Buffer temperature on channel 1 compensates pH on channel 2
              div_start    = 1'b1;                                    // [RULE3]
              div_dividend = 64'(ch2_value) * 64'(s_r.ph_bypass ? 32'h0000_0001 : ch1_value);
              div_divisor  = s_r.ph_bypass ? 32'h1 : tcrp_pkg::PROD_SCALE;
              s_nxt.st     = tcrp_pkg::ST_DIV;
            end
            tcrp_pkg::MATH_SP2: begin
              s_nxt.result = ch1_value;                        // [RULE4]
              s_nxt.sp2    = ch2_value;                        // [RULE4]
              s_nxt.st     = tcrp_pkg::ST_LIN;
            end
            tcrp_pkg::MATH_SUM: begin
              s_nxt.result = ch1_value + ch2_value;            // [RULE5]
              s_nxt.st     = tcrp_pkg::ST_LIN;
            end
            tcrp_pkg::MATH_DIFF: begin
              s_nxt.result = ch1_value - ch2_value;            // [RULE6]
              s_nxt.st     = tcrp_pkg::ST_LIN;
            end
            tcrp_pkg::MATH_RATIO: begin
              div_start    = 1'b1;
              div_dividend = 64'(ch1_value) * 64'(tcrp_pkg::RATIO_SCALE); // [RULE7]
              div_divisor  = ch2_value;
              s_nxt.st     = tcrp_pkg::ST_DIV;
            end
            tcrp_pkg::MATH_PROD: begin
              div_start    = 1'b1;
              div_dividend = 64'(ch1_value) * 64'(ch2_value);  // [RULE8]
              div_divisor  = tcrp_pkg::PROD_SCALE;
              s_nxt.st     = tcrp_pkg::ST_DIV;
            end
            default: begin
              s_nxt.result = ch1_value;                        // [RULE6]
              s_nxt.st     = tcrp_pkg::ST_LIN;
            end
          endcase
        end
      end
      tcrp_pkg::ST_DIV: begin
        // Quotient lands in the result register before any later stage
        if (!div_busy) begin
          s_nxt.result = div_quot;                             // [RULE1]
          s_nxt.st     = tcrp_pkg::ST_LIN;
        end
      end
      tcrp_pkg::ST_LIN: begin
        s_nxt.work = s_r.result;                               // [RULE1]
        if (s_r.d2 != tcrp_pkg::LIN_NONE) begin                // [RULE10]
          if (s_r.d2 == tcrp_pkg::LIN_CASCADE) begin
            // All 32 breakpoints form one curve; outside them the first or last segment is used
            idx = 5'h0;
            for (int i = 1; i < 31; i++) begin
              if (s_r.result[15:0] >= s_r.tab[i][15:0]) idx = 5'(i);
            end
          end else begin
            tsel = (s_r.d2 == tcrp_pkg::LIN_REAR) ? rear_table_sel : 2'(s_r.d2 - tcrp_pkg::LIN_T1);
            idx  = {tsel, 3'h0};
            for (int i = 1; i < 7; i++) begin
              if (s_r.result[15:0] >= s_r.tab[{tsel, 3'(i)}][15:0]) idx = {tsel, 3'(i)};
            end
          end
          s_nxt.work = lin_seg(s_r.result, s_r.tab[idx], s_r.tab[idx + 5'h01]);
        end
        s_nxt.st = tcrp_pkg::ST_FIN;
      end
      tcrp_pkg::ST_FIN: begin
        case (s_r.d1)                                          // [RULE9]
          tcrp_pkg::FIN_SQRT: begin
            s_nxt.sq_rem  = s_r.work;
            s_nxt.sq_root = '0;
            s_nxt.cnt     = 5'(tcrp_pkg::SQRT_CYCLES - 1);
            s_nxt.st      = tcrp_pkg::ST_SQRT;
          end
          tcrp_pkg::FIN_INV: begin
            div_start    = 1'b1;
            div_dividend = 64'(tcrp_pkg::INV_SCALE) * 64'(tcrp_pkg::INV_SCALE);
            div_divisor  = s_r.work;
            s_nxt.st     = tcrp_pkg::ST_INV;
          end
          default: begin
            s_nxt.final_v = s_r.work;
            s_nxt.st      = tcrp_pkg::ST_DONE;
          end
        endcase
      end
      tcrp_pkg::ST_SQRT: begin
        // Bit-by-bit integer square root, MSB first
        trial = 32'({s_r.sq_root | (16'h1 << s_r.cnt[3:0])} * {s_r.sq_root | (16'h1 << s_r.cnt[3:0])});
        if (trial <= s_nxt.sq_rem) begin
          s_nxt.sq_root = s_r.sq_root | (16'h1 << s_r.cnt[3:0]);
        end
        s_nxt.cnt = s_r.cnt - 5'h01;
        if (s_r.cnt == 5'h00) begin
          s_nxt.final_v = {16'h0, s_nxt.sq_root};
          s_nxt.st      = tcrp_pkg::ST_DONE;
        end
      end
      tcrp_pkg::ST_INV: begin
        if (!div_busy) begin
          s_nxt.final_v = div_quot;
          s_nxt.st      = tcrp_pkg::ST_DONE;
        end
      end
      tcrp_pkg::ST_DONE: begin
        s_nxt.valid = 1'b1;
        s_nxt.st    = tcrp_pkg::ST_IDLE;
      end
      default: s_nxt.st = tcrp_pkg::ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r    <= '0;
      s_r.d1 <= tcrp_pkg::CFG_D1_RST;
      s_r.d2 <= tcrp_pkg::CFG_D2_RST;
      s_r.d3 <= tcrp_pkg::CFG_D3_RST;
      s_r.st <= tcrp_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero-wait slave; hrdata is registered in the address phase and holds until the next transfer
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = s_r.rdata;
  assign result_value    = s_r.result;
  assign final_value     = s_r.final_v;
  assign setpoint2_value = s_r.sp2;
  assign result_valid    = s_r.valid;

endmodule : tcrp_core

// File: core/tcrp_pkg.sv
package tcrp_pkg;

  // ------------------------------------------------------------
  // Widths and constants
  // ------------------------------------------------------------
  localparam int unsigned DW            = 32;
  localparam int unsigned TAB_PTS       = 32;
  localparam int unsigned TAB_SEG_W     = 5;
  localparam int unsigned NUM_TABLES    = 4;
  localparam logic [31:0] RATIO_SCALE   = 32'h0000_4e20;   // 20 000
  localparam logic [31:0] PROD_SCALE    = 32'h0000_2710;   // 10 000
  localparam logic [31:0] INV_SCALE     = 32'h0000_2710;   // Squared to form the numerator of 1/x in display counts
  localparam int unsigned DIV_CYCLES    = 32;
  localparam int unsigned SQRT_CYCLES   = 16;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CFG        = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_CH1        = 8'h08;
  localparam logic [7:0] OFS_CH2        = 8'h0c;
  localparam logic [7:0] OFS_RESULT     = 8'h10;
  localparam logic [7:0] OFS_OUT        = 8'h14;
  localparam logic [7:0] OFS_SP2        = 8'h18;
  localparam logic [7:0] OFS_CTRL       = 8'h1c;
  localparam logic [7:0] OFS_TAB_BASE   = 8'h80;   // 32 words of table breakpoints

  // Field positions in the configuration word
  localparam int unsigned CFG_D3_LSB    = 0;
  localparam int unsigned CFG_D2_LSB    = 4;
  localparam int unsigned CFG_D1_LSB    = 8;

  // Reset values
  localparam logic [3:0] CFG_D1_RST     = 4'h0;
  localparam logic [3:0] CFG_D2_RST     = 4'h0;
  localparam logic [3:0] CFG_D3_RST     = 4'h0;

  // Final stage codes
  localparam logic [3:0] FIN_DIRECT     = 4'h0;
  localparam logic [3:0] FIN_SQRT       = 4'h1;
  localparam logic [3:0] FIN_INV        = 4'h2;

  // Linearization codes
  localparam logic [3:0] LIN_NONE       = 4'h0;
  localparam logic [3:0] LIN_T1         = 4'h1;
  localparam logic [3:0] LIN_T4         = 4'h4;
  localparam logic [3:0] LIN_CASCADE    = 4'h5;
  localparam logic [3:0] LIN_REAR       = 4'h6;

  // Math codes
  localparam logic [3:0] MATH_NONE      = 4'h0;
  localparam logic [3:0] MATH_PH        = 4'h1;
  localparam logic [3:0] MATH_SP2       = 4'h2;
  localparam logic [3:0] MATH_SUM       = 4'h3;
  localparam logic [3:0] MATH_DIFF      = 4'h4;
  localparam logic [3:0] MATH_RATIO     = 4'h5;
  localparam logic [3:0] MATH_PROD      = 4'h6;
  localparam logic [3:0] MATH_CH1       = 4'h7;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DIV   = 3'b001,
    ST_LIN   = 3'b010,
    ST_FIN   = 3'b011,
    ST_SQRT  = 3'b100,
    ST_INV   = 3'b101,
    ST_DONE  = 3'b110
  } tcrp_state_e;

endpackage : tcrp_pkg

// File: core/tcrp_divider.sv
`timescale 1ns/10ps
module tcrp_divider (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [63:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             busy,
  output logic [31:0]      quotient
);

  // ------------------------------------------------------------
  // Restoring divider, one quotient bit per cycle
  // ------------------------------------------------------------
  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [63:0] rem;
    logic [63:0] quo;
    logic [31:0] dvs;
  } tcrp_div_s;

  tcrp_div_s s_r;
  tcrp_div_s s_nxt;
  logic [64:0] trial;

  // Shift-subtract step; a zero divisor saturates the quotient
  always_comb begin
    s_nxt = s_r;
    trial = '0;
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = 6'h3f;
      s_nxt.rem  = '0;
      s_nxt.quo  = dividend;
      s_nxt.dvs  = divisor;
    end else if (s_r.busy) begin
      trial = {s_r.rem, s_r.quo[63]} - {33'h0, s_r.dvs};
      if (!trial[64]) begin
        s_nxt.rem = trial[63:0];
        s_nxt.quo = {s_r.quo[62:0], 1'b1};
      end else begin
        s_nxt.rem = {s_r.rem[62:0], s_r.quo[63]};
        s_nxt.quo = {s_r.quo[62:0], 1'b0};
      end
      if (s_r.cnt == 6'h00) begin
        s_nxt.busy = 1'b0;
      end
      s_nxt.cnt = s_r.cnt - 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy     = s_r.busy;
  assign quotient = (s_r.dvs == 32'h0) ? 32'hffff_ffff :
                    ((s_r.quo[63:32] != 32'h0) ? 32'hffff_ffff : s_r.quo[31:0]);

endmodule : tcrp_divider

// File: test/tcrp_core_props.sv
`timescale 1ns/10ps
module tcrp_core_props (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        sample_strobe,
  input  wire logic        mem_large,
  input  wire logic [31:0] result_value,
  input  wire logic [31:0] final_value,
  input  wire logic [31:0] setpoint2_value,
  input  wire logic        result_valid,
  input  wire logic [1:0]  ch1_table,
  input  wire logic [1:0]  ch2_table,
  input  wire logic [1:0]  ch3_table,
  input  wire logic [1:0]  ch4_table
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Sequences of one processing pass and of an unmapped bus read
  // ------------------------------------------------------------
  sequence s_accept;
    sample_strobe && result_valid;
  endsequence
  // Valid drops at once, then a pass must finish within a bounded time
  sequence s_done;
    ##1 !result_valid ##[1:400] result_valid;
  endsequence
  sequence s_unmapped_rd;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h40;
  endsequence

  property p_pass;
    s_accept |-> s_done;
  endproperty
  property p_tab3;
    ch3_table == (mem_large ? 2'h2 : 2'h0);
  endproperty
  property p_tab4;
    ch4_table == (mem_large ? 2'h3 : 2'h0);
  endproperty
  property p_shared;
    !mem_large |-> ch1_table == 2'h0 && ch2_table == 2'h0;
  endproperty
  // Outputs of a finished pass must not drift before the next strobe
  property p_res_hold;
    result_valid && !sample_strobe |=> $stable(result_value);
  endproperty
  property p_fin_hold;
    result_valid && !sample_strobe |=> $stable(final_value);
  endproperty
  property p_sp2_hold;
    result_valid && !sample_strobe |=> $stable(setpoint2_value);
  endproperty
  property p_unmapped;
    s_unmapped_rd |=> hrdata == 32'h0;
  endproperty

  a_pass: assert property (p_pass) else $error("processing pass did not complete in time");
  a_tab3: assert property (p_tab3) else $error("channel 3 table index wrong");
  a_tab4: assert property (p_tab4) else $error("channel 4 table index wrong");
  a_shared: assert property (p_shared) else $error("small memory must use the shared table");
  a_res_hold: assert property (p_res_hold) else $error("result register changed while idle");
  a_fin_hold: assert property (p_fin_hold) else $error("final value changed while idle");
  a_sp2_hold: assert property (p_sp2_hold) else $error("setpoint 2 changed while idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : tcrp_core_props

bind tcrp_core tcrp_core_props tcrp_core_props_i (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .sample_strobe, .mem_large, .result_value, .final_value, .setpoint2_value, .result_valid,
  .ch1_table, .ch2_table, .ch3_table, .ch4_table);

// File: test/tcrp_chan_src.sv
`timescale 1ns/10ps
module tcrp_chan_src (
  input  wire logic        clock,
  output logic [31:0]      ch1_value,
  output logic [31:0]      ch2_value,
  output logic             sample_strobe
);
  initial begin
    ch1_value = 32'h0;
    ch2_value = 32'h0;
    sample_strobe = 1'b0;
  end

  // One sample after an optional delay; values are only good with the strobe,
  // so they are inverted afterwards to expose a late capture
  task automatic send(input logic [31:0] a, input logic [31:0] b, input int gap);
    repeat (gap) @(posedge clock);
    ch1_value <= a;
    ch2_value <= b;
    sample_strobe <= 1'b1;
    @(posedge clock);
    sample_strobe <= 1'b0;
    ch1_value <= ~a;
    ch2_value <= ~b;
  endtask : send
endmodule : tcrp_chan_src

// File: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed { logic [31:0] res; logic [31:0] fin; } tcrp_tb_exp_s;
  logic         clock, rst, hsel, hwrite, hresp, hreadyout, sample_strobe;
  logic         mem_large, ch1_volt_curr, result_valid, vld_q;
  logic [1:0]   htrans, rear_table_sel, ch1_table_sel, ch2_table_sel;
  logic [1:0]   ch1_table, ch2_table, ch3_table, ch4_table;
  logic [2:0]   hsize, ch_analog;
  logic [31:0]  haddr, hwdata, hrdata, ch1_value, ch2_value, rd, cfg, res, seed;
  logic [31:0]  result_value, final_value, setpoint2_value;
  int           err_count, samples_checked;
  tcrp_tb_exp_s exp_q[$];
  tcrp_tb_exp_s e_mon;

  tcrp_core tcrp_core_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch1_value(ch1_value), .ch2_value(ch2_value),
    .sample_strobe(sample_strobe), .mem_large(mem_large), .ch1_volt_curr(ch1_volt_curr),
    .ch_analog(ch_analog), .rear_table_sel(rear_table_sel), .ch1_table_sel(ch1_table_sel),
    .ch2_table_sel(ch2_table_sel), .result_value(result_value), .final_value(final_value),
    .setpoint2_value(setpoint2_value), .result_valid(result_valid), .ch1_table(ch1_table),
    .ch2_table(ch2_table), .ch3_table(ch3_table), .ch4_table(ch4_table));
  tcrp_chan_src tcrp_chan_src_i (.clock(clock), .ch1_value(ch1_value), .ch2_value(ch2_value),
    .sample_strobe(sample_strobe));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  // Widened to 64 bits so ratio and product keep their high bits
  function automatic logic [31:0] f_math(input logic [3:0] d, input logic [31:0] a, b, p);
    logic [63:0] w;
    case (d)
      4'h0: w = {32'h0, p};
      4'h1, 4'h6: w = ({32'h0, a} * {32'h0, b}) / tcrp_pkg::PROD_SCALE;
      4'h2, 4'h7: w = {32'h0, a};
      4'h3: w = {32'h0, a + b};
      4'h4: w = {32'h0, a - b};
      default: w = ({32'h0, a} * tcrp_pkg::RATIO_SCALE) / {32'h0, b};
    endcase
    return w[31:0];
  endfunction : f_math

  function automatic logic [31:0] f_fin(input logic [3:0] d1, input logic [31:0] r);
    logic [31:0] q;
    q = 32'h0;
    if (d1 == 4'h1) begin
      for (int i = 15; i >= 0; i--) if ((q | (32'h1 << i)) * (q | (32'h1 << i)) <= r) q = q | (32'h1 << i);
      return q;
    end
    if (d1 == 4'h2) return (r == 32'h0) ? 32'hffffffff : 32'((64'(tcrp_pkg::INV_SCALE) * tcrp_pkg::INV_SCALE) / r);
    return r;
  endfunction : f_fin

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdv = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic pass(input logic [3:0] d1, input logic [3:0] d3);
    logic [31:0] a, b;
    seed = xorshift(seed);
    a = {22'h0, seed[9:0]} + 32'h1;
    b = {22'h0, seed[25:16]} + 32'h1;
    bus(1'b1, 32'h0, {20'h0, d1, 4'h0, d3}, rd);
    res = f_math(d3, a, b, res);
    exp_q.push_back('{res, f_fin(d1, res)});
    tcrp_chan_src_i.send(a, b, int'(seed[29:28]));
    repeat (2) @(posedge clock);
    while (result_valid !== 1'b1) @(posedge clock);
    if (d3 == 4'h2) check(setpoint2_value, b);
  endtask : pass

  task automatic close_out();
    $display("Comparisons: %0d, mismatches: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // Clock, watchdog, result monitor
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    close_out();
  end

  // Each rising edge of valid retires the oldest expected result
  always @(posedge clock) begin
    vld_q <= result_valid;
    if (result_valid === 1'b1 && vld_q !== 1'b1 && exp_q.size() > 0) begin
      e_mon = exp_q.pop_front();
      check(result_value, e_mon.res);
      check(final_value, e_mon.fin);
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mem_large = 1'b1;
    ch1_volt_curr = 1'b1;
    ch_analog = 3'h0;
    rear_table_sel = 2'h1;
    ch1_table_sel = 2'h2;
    ch2_table_sel = 2'h3;
    err_count = 0;
    samples_checked = 0;
    seed = 32'd42;
    res = 32'h0;
    vld_q = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 32'h40, 32'h0, rd);
    check(rd, 32'h0);
    for (int d1 = 0; d1 < 3; d1++)
      for (int d3 = 0; d3 < 8; d3++) pass(4'(d1), 4'(d3));
    cfg = 32'h207;
    // Walk every linearization code against memory size and channel modes
    for (int i = 0; i < 64; i++) begin
      mem_large <= i[0];
      ch_analog <= i[1] ? 3'h4 : 3'h0;
      ch1_volt_curr <= ~i[2];
      @(posedge clock);
      bus(1'b1, 32'h0, {20'h0, 4'h1, 4'(i >> 3), 4'h3}, rd);
      if (!(i[5:3] > 6 || (i[5:3] > 1 && !i[0]) || (i[5:3] != 0 && i[2:1] != 0))) cfg = {20'h0, 4'h1, 4'(i >> 3), 4'h3};
      bus(1'b0, 32'h0, 32'h0, rd);
      check(rd, cfg);
    end
    bus(1'b1, 32'h0, 32'h308, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    check(rd, cfg);
    // Second reset in mid-run must clear result and configuration
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(result_value, 32'h0);
    bus(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h0);
    close_out();
  end
endmodule : testbench
